/* File: coex_params.svh */
// Constants for the narrowband radio coexistence handshake.
// Assumes inclusion by bare name from every file that needs the timing or bundle layout.
`ifndef COEX_PARAMS_SVH
`define COEX_PARAMS_SVH

// Clock period of the radio domain in nanoseconds.
`define COEX_CLK_PERIOD_NS 10

// Least time that the request leads the start of a radio event, in nanoseconds.
`define COEX_LEAD_TIME_NS 2000

// Lead time in clock cycles, rounded up to whole cycles.
`define COEX_LEAD_CYCLES ((`COEX_LEAD_TIME_NS + `COEX_CLK_PERIOD_NS - 1) / `COEX_CLK_PERIOD_NS)

// Number of flip-flops in each pin synchroniser.
`define COEX_SYNC_STAGES 2

// Bit positions inside the four-bit coexistence bundle.
`define COEX_BND_REQ_BIT 0
`define COEX_BND_DIR_BIT 1
`define COEX_BND_URG_LSB 2
`define COEX_BND_URG_MSB 3

// Reset values of the pin outputs.
`define COEX_REQ_RST 1'h0
`define COEX_DIR_RST 1'h0
`define COEX_URG_RST 2'h0
`define COEX_PEER_INH_RST 1'h0

`endif

/* File: coex_pkg.sv */
// Types shared by the coexistence handshake, its checker and its test bench.
// Assumes coex_params.svh is available on the include path.
`default_nettype none
`include "coex_params.svh"

package coex_pkg;

  // Handshake states, Gray coded along idle, lead, active, halt.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_LEAD   = 2'h1,
    ST_ACTIVE = 2'h3,
    ST_HALT   = 2'h2
  } coex_state_t;

  // Event request from the radio sequencer.
  typedef struct packed {
    logic       pending;
    logic       is_tx;
    logic [1:0] urgency;
  } seq_req_t;

  // Four-bit bundle routed to the general outputs, most significant first.
  typedef struct packed {
    logic [1:0] urgency;
    logic       direction;
    logic       request;
  } coex_bundle_t;

  // Status seen by the radio control logic.
  typedef struct packed {
    coex_state_t state;
    logic        tx_blocked;
    logic        rx_blocked;
    logic        inhibit_seen;
    logic [7:0]  deny_count;
  } coex_status_t;

endpackage

`default_nettype wire

/* File: coex_sync.sv */
// Multi-bit level synchroniser with a fixed number of stages.
// Assumes each bit is an independent level; no word coherence across bits.
`timescale 1ns/100ps
`default_nettype none
`include "coex_params.svh"

module coex_sync #(
  parameter int unsigned WIDTH  = 1,
  parameter int unsigned STAGES = `COEX_SYNC_STAGES
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Asynchronous levels in, synchronous levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_q [STAGES];

  // Parameter check at elaboration.
  if (WIDTH < 1 || STAGES < 2) begin : g_bad_params
    $error("coex_sync needs at least one bit and two stages");
  end

  // Only the next stage reads the first stage.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= '0;
      end
    end else begin
      stage_q[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign sync_out = stage_q[STAGES-1];

endmodule

`default_nettype wire

/* File: radio_coexistence_handshake.sv */
// Narrowband radio side of the coexistence handshake with a wireless LAN transceiver.
// Assumes the sequencer and configuration inputs are on clk; the peer pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "coex_params.svh"

module radio_coexistence_handshake #(
  parameter int unsigned LEAD_CYCLES = `COEX_LEAD_CYCLES,
  parameter int unsigned CNT_W       = 16
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Configuration from the radio control logic
  input  wire logic                  cfg_nb_master,
  input  wire logic                  cfg_rx_block_en,
  input  wire logic                  cfg_dir_force_en,
  input  wire logic                  cfg_dir_force_val,
  input  wire logic                  cfg_kind_report_en,
  input  wire logic                  cfg_chan_separated,
  // Radio sequencer
  input  wire coex_pkg::seq_req_t    seq_req,
  input  wire logic                  seq_done,
  output logic                       seq_go,
  output logic                       seq_abort,
  // Coexistence pins
  input  wire logic                  radio_inhibit_in,
  input  wire logic                  peer_tx_in,
  output logic                       radio_request_out,
  output logic                       activity_direction_out,
  output logic [1:0]                 urgent_access_out,
  output logic                       peer_inhibit_out,
  output coex_pkg::coex_bundle_t     coex_bundle_out,
  // Status
  output coex_pkg::coex_status_t     status_out
);

  // Registered state and pin values, then the combinational decisions that feed them.
  coex_pkg::coex_state_t state_q;
  coex_pkg::coex_state_t state_d;
  logic [CNT_W-1:0]      lead_cnt_q;
  logic                  dir_q;
  logic [1:0]            urg_q;
  logic                  req_out_q;
  logic                  dir_out_q;
  logic [1:0]            urg_out_q;
  logic                  peer_inh_q;
  coex_pkg::coex_bundle_t bundle_q;
  logic [7:0]            deny_cnt_q;
  logic                  inhibit_s;
  logic                  peer_tx_s;
  logic                  tx_blocked;
  logic                  rx_blocked;
  logic                  blocked;
  logic                  start_evt;
  logic                  abort_evt;
  logic                  dir_now;

  // The lead counter counts down from this load to zero, which makes the lead LEAD_CYCLES edges.
  localparam logic [CNT_W-1:0] LEAD_LOAD = CNT_W'(LEAD_CYCLES - 1);

  // Parameter checks at elaboration: the counter must hold the load and the bundle must stay four bits.
  if (CNT_W < 1 || CNT_W > 31) begin : g_bad_cnt_w
    $error("CNT_W must lie between 1 and 31");
  end
  if (LEAD_CYCLES < 1 || LEAD_CYCLES > (2 ** CNT_W)) begin : g_bad_lead
    $error("LEAD_CYCLES must be at least one and fit the lead counter");
  end
  if ($bits(coex_pkg::coex_bundle_t) != 4) begin : g_bad_bundle
    $error("the coexistence bundle must be four bits wide");
  end

  // Both peer pins cross into this clock through the same two-stage synchroniser.
  // inhibit synchroniser
  coex_sync #(
    .WIDTH  (2),
    .STAGES (`COEX_SYNC_STAGES)
  ) u_pin_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({peer_tx_in, radio_inhibit_in}),
    .sync_out ({peer_tx_s, inhibit_s})
  );

  // The direction that the event will use on the pins and for blocking.
  // In idle the sequencer's bit is used directly, so blocking is judged for the event about to be taken.
  assign dir_now = (state_q == coex_pkg::ST_IDLE) ? seq_req.is_tx : dir_q;

  // Blocking is decided only when the peer is master; as master this radio owns the band.
  // Only synchronised pin levels are read here, so every consumer sees a pin edge in the same cycle.
  // In master mode nothing blocks: the peer is held off through its own inhibit line instead.
  always_comb begin
    tx_blocked = 1'b0;
    rx_blocked = 1'b0;
    if (!cfg_nb_master) begin
      tx_blocked = inhibit_s;
      rx_blocked = inhibit_s & cfg_rx_block_en;
      if (cfg_kind_report_en && !peer_tx_s) begin
        rx_blocked = 1'b0;
      end
      if (cfg_kind_report_en && cfg_chan_separated) begin
        rx_blocked = 1'b0;
      end
    end
  end

  // Blocking follows the direction of the event: transmit and receive are denied separately.
  // inhibit stops activity
  assign blocked = dir_now ? tx_blocked : rx_blocked;

  // A blocked event waits in lead with its request held; an abort marks an active event losing the band.
  assign start_evt = (state_q == coex_pkg::ST_LEAD) && (lead_cnt_q == '0) && !blocked && seq_req.pending;
  assign abort_evt = (state_q == coex_pkg::ST_ACTIVE) && blocked && !seq_done;

  // The go and abort strobes are combinational so that the sequencer stops in the cycle the denial is seen.
  // halt without waiting a cycle
  assign seq_go    = (state_q == coex_pkg::ST_ACTIVE) && !blocked;
  assign seq_abort = abort_evt;

  // Next state of the handshake.
  // Idle waits for a pending event; lead holds the request for the lead time before the start.
  // Active runs the event while the band is free; halt keeps the request after a denial
  // until the sequencer finishes or withdraws, so the peer sees one request per event.
  always_comb begin
    state_d = state_q;
    case (state_q)
      coex_pkg::ST_IDLE: begin
        if (seq_req.pending) begin
          state_d = coex_pkg::ST_LEAD;
        end
      end
      coex_pkg::ST_LEAD: begin
        if (!seq_req.pending) begin
          state_d = coex_pkg::ST_IDLE;
        end else if (start_evt) begin
          state_d = coex_pkg::ST_ACTIVE;
        end
      end
      coex_pkg::ST_ACTIVE: begin
        if (seq_done) begin
          state_d = coex_pkg::ST_IDLE;
        end else if (blocked) begin
          state_d = coex_pkg::ST_HALT;
        end
      end
      coex_pkg::ST_HALT: begin
        if (seq_done || !seq_req.pending) begin
          state_d = coex_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = coex_pkg::ST_IDLE;
      end
    endcase
  end

  // The Gray coding keeps every step except active to idle to a single bit change.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= coex_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Reloaded in idle, so an event withdrawn during its lead gets a full lead the next time.
  // lead time before event
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lead_cnt_q <= '0;
    end else if (state_q == coex_pkg::ST_IDLE) begin
      lead_cnt_q <= LEAD_LOAD;
    end else if (state_q == coex_pkg::ST_LEAD && lead_cnt_q != '0) begin
      lead_cnt_q <= lead_cnt_q - CNT_W'(1);
    end
  end

  // Direction and urgency are taken when the request is raised and kept for the event.
  // Later changes on the sequencer's fields are ignored until the handshake returns to idle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_q <= `COEX_DIR_RST;
      urg_q <= `COEX_URG_RST;
    end else if (state_q == coex_pkg::ST_IDLE && seq_req.pending) begin
      dir_q <= seq_req.is_tx;
      urg_q <= seq_req.urgency;
    end
  end

  // Pin registers follow the next state, so every pin to the peer moves on the edge that leaves or enters idle, except a forced direction or a role change.
  // request held until end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_out_q <= `COEX_REQ_RST;
    end else begin
      req_out_q <= (state_d != coex_pkg::ST_IDLE);
    end
  end

  // Direction pin, with the software force taking precedence over the sequencer.
  // Outside an event the pin rests low unless software forces it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_out_q <= `COEX_DIR_RST;
    end else if (cfg_dir_force_en) begin
      dir_out_q <= cfg_dir_force_val;
    end else if (state_d != coex_pkg::ST_IDLE) begin
      dir_out_q <= (state_q == coex_pkg::ST_IDLE) ? seq_req.is_tx : dir_q;
    end else begin
      dir_out_q <= `COEX_DIR_RST;
    end
  end

  // Urgency drops to zero in idle so that a stale priority is never shown between events.
  // urgency while requesting
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      urg_out_q <= `COEX_URG_RST;
    end else if (state_d == coex_pkg::ST_IDLE) begin
      urg_out_q <= `COEX_URG_RST;
    end else if (state_q == coex_pkg::ST_IDLE) begin
      urg_out_q <= seq_req.urgency;
    end else begin
      urg_out_q <= urg_q;
    end
  end

  // As master this radio ignores the inhibit pin and holds the peer off while it requests.
  // master inhibits the peer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      peer_inh_q <= `COEX_PEER_INH_RST;
    end else begin
      peer_inh_q <= cfg_nb_master && (state_d != coex_pkg::ST_IDLE);
    end
  end

  // The bundle repeats the pin values register for register, so it can be routed in place of the pins.
  // bundle packing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bundle_q <= '0;
    end else begin
      bundle_q.request   <= (state_d != coex_pkg::ST_IDLE);
      bundle_q.direction <= cfg_dir_force_en ? cfg_dir_force_val :
                            ((state_d == coex_pkg::ST_IDLE) ? `COEX_DIR_RST :
                            ((state_q == coex_pkg::ST_IDLE) ? seq_req.is_tx : dir_q));
      bundle_q.urgency   <= (state_d == coex_pkg::ST_IDLE) ? `COEX_URG_RST :
                            ((state_q == coex_pkg::ST_IDLE) ? seq_req.urgency : urg_q);
    end
  end

  // Saturating count of events cut short by the peer.
  // It saturates rather than wraps, so a long run of denials never reads as a few.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      deny_cnt_q <= 8'h00;
    end else if (abort_evt && deny_cnt_q != 8'hff) begin
      deny_cnt_q <= deny_cnt_q + 8'h01;
    end
  end

  // Pin outputs come straight from their registers.
  assign radio_request_out      = req_out_q;
  assign activity_direction_out = dir_out_q;
  assign urgent_access_out      = urg_out_q;
  assign peer_inhibit_out       = peer_inh_q;
  assign coex_bundle_out        = bundle_q;

  // Status is combinational so that control logic sees blocking in the cycle in which it applies.
  always_comb begin
    status_out              = '0;
    status_out.state        = state_q;
    status_out.tx_blocked   = tx_blocked;
    status_out.rx_blocked   = rx_blocked;
    status_out.inhibit_seen = inhibit_s;
    status_out.deny_count   = deny_cnt_q;
  end

endmodule

`default_nettype wire

/* File: coex_checker.sv */
// Concurrent checks on the coexistence handshake ports.
// Assumes one clock domain and bind to every instance of the top module.
`timescale 1ns/100ps
`default_nettype none

module coex_checker (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   nrst,
  // Configuration and sequencer
  input wire logic                   cfg_nb_master,
  input wire logic                   cfg_rx_block_en,
  input wire logic                   cfg_dir_force_en,
  input wire logic                   cfg_dir_force_val,
  input wire logic                   cfg_kind_report_en,
  input wire coex_pkg::seq_req_t     seq_req,
  input wire logic                   seq_done,
  input wire logic                   seq_go,
  input wire logic                   seq_abort,
  // Pins
  input wire logic                   radio_inhibit_in,
  input wire logic                   radio_request_out,
  input wire logic                   activity_direction_out,
  input wire logic [1:0]             urgent_access_out,
  input wire logic                   peer_inhibit_out,
  input wire coex_pkg::coex_bundle_t coex_bundle_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_denied;
    (!cfg_nb_master && !cfg_kind_report_en && cfg_rx_block_en && radio_inhibit_in)[*3];
  endsequence
  sequence s_halted;
    !seq_go ##1 (!seq_go && !seq_abort);
  endsequence

  a_bundle_layout: assert property (coex_bundle_out == {urgent_access_out, activity_direction_out, radio_request_out})
    else $error("bundle differs from pins");
  a_request_leads: assert property ($rose(radio_request_out) |-> !seq_go ##1 !seq_go)
    else $error("event started without lead");
  a_request_holds: assert property (radio_request_out && seq_req.pending && !seq_done |=> radio_request_out)
    else $error("request dropped mid event");
  a_pins_latched: assert property ($rose(radio_request_out) && !cfg_dir_force_en |->
    activity_direction_out == $past(seq_req.is_tx) && urgent_access_out == $past(seq_req.urgency))
    else $error("direction or urgency wrong");
  a_dir_forced: assert property (cfg_dir_force_en && $past(cfg_dir_force_en) && $stable(cfg_dir_force_val) |->
    activity_direction_out == cfg_dir_force_val)
    else $error("forced direction not shown");
  a_inhibit_stops: assert property (s_denied |-> !seq_go)
    else $error("activity while denied");
  a_abort_halts: assert property (seq_abort |-> s_halted)
    else $error("abort did not halt");
  a_master_role: assert property ($stable(cfg_nb_master) |-> peer_inhibit_out == (cfg_nb_master && radio_request_out))
    else $error("peer inhibit wrong for role");
endmodule

bind radio_coexistence_handshake coex_checker u_chk (.clk, .nrst, .cfg_nb_master, .cfg_rx_block_en,
  .cfg_dir_force_en, .cfg_dir_force_val, .cfg_kind_report_en, .seq_req, .seq_done, .seq_go, .seq_abort,
  .radio_inhibit_in, .radio_request_out, .activity_direction_out, .urgent_access_out, .peer_inhibit_out,
  .coex_bundle_out);
`default_nettype wire

/* File: wlan_peer_model.sv */
// Behavioural wireless LAN transceiver on the far side of the handshake.
// Assumes the bench sets deny and kind_tx; pins change just after the clock edge.
`timescale 1ns/100ps
`default_nettype none

module wlan_peer_model (
  // Clock
  input  wire logic clk,
  // Bench control and radio pins
  input  wire logic deny,
  input  wire logic kind_tx,
  input  wire logic peer_inhibit_out,
  output var  logic radio_inhibit_in,
  output var  logic peer_tx_in,
  output var  logic antenna_free_in
);
  always @(posedge clk) radio_inhibit_in <= #1 deny;
  always @(posedge clk) peer_tx_in <= #1 kind_tx && !peer_inhibit_out;
  always @(posedge clk) antenna_free_in <= #1 !deny;
endmodule
`default_nettype wire

/* File: radio_coexistence_handshake_test.sv */
// Self-checking bench for the coexistence handshake with a peer model.
// Assumes coex_checker is bound to the design and LEAD_CYCLES is set small.
`timescale 1ns/100ps
`default_nettype none

module radio_coexistence_handshake_test;
  logic clk = 1'h0, nrst = 1'h0, go_q = 1'h0;
  logic m = 1'h0, rxb = 1'h1, fe = 1'h0, fv = 1'h0, kr = 1'h0, sep = 1'h0;
  logic deny = 1'h0, ktx = 1'h0, done = 1'h0, go, ab, inh, ptx, req, dir, pin, free;
  logic [1:0] urg;
  coex_pkg::seq_req_t     sreq = '0;
  coex_pkg::coex_bundle_t bnd;
  coex_pkg::coex_status_t st;
  logic [5:0] q[$];
  int fails = 0, samples_checked = 0;
  logic [31:0] x = 32'h24, r;

  always #5 clk = ~clk;

  radio_coexistence_handshake #(.LEAD_CYCLES(2)) uut (.clk, .nrst, .cfg_nb_master(m), .cfg_rx_block_en(rxb),
    .cfg_dir_force_en(fe), .cfg_dir_force_val(fv), .cfg_kind_report_en(kr), .cfg_chan_separated(sep),
    .seq_req(sreq), .seq_done(done), .seq_go(go), .seq_abort(ab), .radio_inhibit_in(inh), .peer_tx_in(ptx),
    .radio_request_out(req), .activity_direction_out(dir), .urgent_access_out(urg), .peer_inhibit_out(pin),
    .coex_bundle_out(bnd), .status_out(st));
  wlan_peer_model peer (.clk, .deny, .kind_tx(ktx), .peer_inhibit_out(pin), .radio_inhibit_in(inh),
    .peer_tx_in(ptx), .antenna_free_in(free));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction

  task automatic check(input string nm, input logic [5:0] seen, input logic [5:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude;
    check("queue", 6'(q.size()), 6'h0);
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Grant and abort results, oldest note first, sampled mid-cycle where the outputs are settled.
  always @(negedge clk) begin
    if ((go && !go_q) || ab) check("result", {pin, ab, bnd}, q.pop_front());
    go_q <= go;
  end

  task automatic ev(input logic tx, input logic [1:0] u, input logic abrt, input logic d);
    q.push_back({m, 1'h0, u, d, 1'h1});
    @(posedge clk) #1 sreq = {1'h1, tx, u};
    for (int n = 0; n < 200 && go !== 1'h1; n++) @(posedge clk) #1;
    if (abrt) begin
      q.push_back({m, 1'h1, u, d, 1'h1});
      deny = 1'h1;
      for (int n = 0; n < 10 && ab !== 1'h1; n++) @(posedge clk) #1;
      @(posedge clk) #1 sreq.pending = 1'h0;
      deny = 1'h0;
    end else begin
      done = 1'h1;
      sreq.pending = 1'h0;
      @(posedge clk) #1 done = 1'h0;
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1 nrst = 1'h1;
    for (int i = 0; i < 8; i++) begin
      x = xs(x);
      r = x;
      ev(r[0], r[2:1], 1'h0, r[0]);
    end
    fe = 1'h1;
    fv = 1'h1;
    ev(1'h0, 2'h2, 1'h0, 1'h1);
    fe = 1'h0;
    ev(1'h1, 2'h3, 1'h1, 1'h1);
    @(posedge clk) #1 deny = 1'h1;
    fork
      ev(1'h0, 2'h1, 1'h0, 1'h0);
      begin
        repeat (12) @(posedge clk);
        #1 check("held", {5'h0, go}, 6'h0);
        check("free", {5'h0, free}, 6'h0);
        deny = 1'h0;
      end
    join
    {kr, sep, deny, ktx} = 4'hf;
    ev(1'h0, 2'h1, 1'h0, 1'h0);
    {sep, ktx} = 2'h0;
    ev(1'h0, 2'h0, 1'h0, 1'h0);
    {kr, m} = 2'h1;
    ev(1'h1, 2'h1, 1'h0, 1'h1);
    repeat (4) @(posedge clk);
    check("denials", 6'(st.deny_count), 6'h1);
    conclude();
  end

  initial begin
    #200000;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
